// File: rtl/cgt_consts.svh
// Register offsets, field positions and reset values of the timer block
`ifndef CGT_CONSTS_SVH
`define CGT_CONSTS_SVH

`define CGT_OFF_CTRL_LO    8'h00
`define CGT_OFF_CTRL_HI    8'h04
`define CGT_OFF_STATUS     8'h08
`define CGT_OFF_CNT_LO     8'h0c
`define CGT_OFF_CNT_HI     8'h10
`define CGT_OFF_PER_LO     8'h14
`define CGT_OFF_PER_HI     8'h18
`define CGT_OFF_IRQ_STAT   8'h1c
`define CGT_OFF_IRQ_MASK   8'h20

`define CGT_BIT_ON         15
`define CGT_FLD_CLKSEL     10:8
`define CGT_BIT_WIDE       5
`define CGT_BIT_CAPSEL     4
`define CGT_FLD_FUNC       3:0
`define CGT_BIT_TRIGGER_MODE_ENABLE     7
`define CGT_FLD_SYNCSEL    4:0
`define CGT_BIT_ARMED      7
`define CGT_BIT_TRIGGER_CLEAR      5

`define CGT_IRQ_SYNC       0
`define CGT_IRQ_CMP        1
`define CGT_IRQ_TRIG       2

`define CGT_FUNC_TIMER     4'h0
`define CGT_PERIOD_RESET   16'hffff
`define CGT_HRESP_OKAY     1'b0

`endif

// File: rtl/cgt_pkg.sv
// Types shared by the timer block
package cgt_pkg;
    typedef enum logic [1:0] {
        CGT_IDLE,
        CGT_DUAL,
        CGT_WIDE
    } cgt_mode_e;
endpackage : cgt_pkg

// File: rtl/cgt_timer.sv
// General purpose dual 16-bit / single 32-bit timer with AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "cgt_consts.svh"

module cgt_timer (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [31:0] syncSources,
    output logic             syncOut,
    output logic             compareEvent,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic [15:0]       ctrlLo_q;
    logic [15:0]       ctrlHi_q;
    logic [15:0]       cntLo_q;
    logic [15:0]       cntHi_q;
    logic [15:0]       perLo_q;
    logic [15:0]       perHi_q;
    logic              armed_q;
    logic [2:0]        irqStat_q;
    logic [2:0]        irqMask_q;
    logic              wrPend_q;
    logic              rdPend_q;
    logic [7:0]        busAddr_q;
    logic [31:0]       hrdata_q;
    logic              hready_q;
    logic              syncOut_q;
    logic              compareEvent_q;
    logic              irq_q;

    logic [15:0]       cntLo_d;
    logic [15:0]       cntHi_d;
    logic              syncEv;
    logic              cmpEv;
    cgt_pkg::cgt_mode_e mode;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode

    wire        addrPhase = hsel & htrans[1] & hready;
    wire        wrEn      = wrPend_q;
    wire        rdDone    = rdPend_q;
    wire        wrCtrlLo  = wrEn & (busAddr_q == `CGT_OFF_CTRL_LO);
    wire        wrCtrlHi  = wrEn & (busAddr_q == `CGT_OFF_CTRL_HI);
    wire        wrStatus  = wrEn & (busAddr_q == `CGT_OFF_STATUS);
    wire        wrCntLo   = wrEn & (busAddr_q == `CGT_OFF_CNT_LO);
    wire        wrCntHi   = wrEn & (busAddr_q == `CGT_OFF_CNT_HI);
    wire        wrPerLo   = wrEn & (busAddr_q == `CGT_OFF_PER_LO);
    wire        wrPerHi   = wrEn & (busAddr_q == `CGT_OFF_PER_HI);
    wire        wrMask    = wrEn & (busAddr_q == `CGT_OFF_IRQ_MASK);
    wire        rdIrqStat = rdDone & (busAddr_q == `CGT_OFF_IRQ_STAT);

    wire [31:0] rdMux =
        (busAddr_q == `CGT_OFF_CTRL_LO)  ? {16'h0000, ctrlLo_q} :
        (busAddr_q == `CGT_OFF_CTRL_HI)  ? {16'h0000, ctrlHi_q} :
        (busAddr_q == `CGT_OFF_STATUS)   ?
            {24'h000000, armed_q, 7'h00} :
        (busAddr_q == `CGT_OFF_CNT_LO)   ? {16'h0000, cntLo_q} :
        (busAddr_q == `CGT_OFF_CNT_HI)   ? {16'h0000, cntHi_q} :
        (busAddr_q == `CGT_OFF_PER_LO)   ? {16'h0000, perLo_q} :
        (busAddr_q == `CGT_OFF_PER_HI)   ? {16'h0000, perHi_q} :
        (busAddr_q == `CGT_OFF_IRQ_STAT) ? {29'h00000000, irqStat_q} :
        (busAddr_q == `CGT_OFF_IRQ_MASK) ? {29'h00000000, irqMask_q} :
        32'h00000000;

    ////////////////////////////////////////////////////////////////////////
    // Timer control decode

    wire timerMode = ctrlLo_q[`CGT_BIT_ON] & ~ctrlLo_q[`CGT_BIT_CAPSEL]
                   & (ctrlLo_q[`CGT_FLD_FUNC] == `CGT_FUNC_TIMER);
    wire wide      = ctrlLo_q[`CGT_BIT_WIDE];
    wire trigger_mode_enable    = ctrlHi_q[`CGT_BIT_TRIGGER_MODE_ENABLE];
    wire selIn     = syncSources[ctrlHi_q[`CGT_FLD_SYNCSEL]];
    wire trClrWr   = wrStatus & hwdata[`CGT_BIT_TRIGGER_CLEAR];
    wire trigEvent = timerMode & trigger_mode_enable & selIn;
    // sync clears, trigger holds until armed
    // trigger clear resets the primary time base
    wire primClr   = (~trigger_mode_enable & selIn) | (trigger_mode_enable & ~armed_q) | trClrWr;
    wire lowMatch  = cntLo_q == perLo_q;
    wire hiMatch   = cntHi_q == perHi_q;
    wire wideMatch = lowMatch & hiMatch;

    assign mode = ~timerMode ? cgt_pkg::CGT_IDLE :
                  wide       ? cgt_pkg::CGT_WIDE : cgt_pkg::CGT_DUAL;

    always_comb begin
        cntLo_d = cntLo_q;
        cntHi_d = cntHi_q;
        syncEv  = 1'b0;
        cmpEv   = 1'b0;
        case (mode)
            cgt_pkg::CGT_DUAL: begin
                // primary half on the low registers
                cntLo_d = primClr ? 16'h0000 :
                          lowMatch ? 16'h0000 : cntLo_q + 16'h0001;
                // secondary half free of sync and trigger
                cntHi_d = hiMatch ? 16'h0000 : cntHi_q + 16'h0001;
                // primary period match drives sync out
                syncEv  = ~primClr & lowMatch;
                // secondary match is the compare event
                cmpEv   = hiMatch;
            end
            cgt_pkg::CGT_WIDE: begin
                // carry from low half into high half
                {cntHi_d, cntLo_d} = primClr   ? 32'h00000000 :
                                     wideMatch ? 32'h00000000 :
                                     {cntHi_q, cntLo_q} + 32'h00000001;
                syncEv  = ~primClr & wideMatch;
                cmpEv   = ~primClr & wideMatch;
            end
            default: begin
                cntLo_d = cntLo_q;
                cntHi_d = cntHi_q;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus slave: reads take one wait state so read data is a flop

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wrPend_q  <= 1'b0;
            rdPend_q  <= 1'b0;
            busAddr_q <= 8'h00;
            hrdata_q  <= 32'h00000000;
            hready_q  <= 1'b1;
        end else if (ce) begin
            wrPend_q <= addrPhase & hwrite;
            rdPend_q <= addrPhase & ~hwrite;
            hready_q <= ~(addrPhase & ~hwrite);
            if (addrPhase) begin
                busAddr_q <= haddr[7:0];
            end
            if (rdDone) begin
                hrdata_q <= rdMux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers

    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctrlLo_q  <= 16'h0000;
            ctrlHi_q  <= 16'h0000;
            perLo_q   <= `CGT_PERIOD_RESET;
            perHi_q   <= `CGT_PERIOD_RESET;
            irqMask_q <= 3'h0;
        end else if (ce) begin
            if (wrCtrlLo) ctrlLo_q <= hwdata[15:0];
            if (wrCtrlHi) ctrlHi_q <= hwdata[15:0];
            if (wrPerLo) perLo_q <= hwdata[15:0];
            if (wrPerHi) perHi_q <= hwdata[15:0];
            if (wrMask) irqMask_q <= hwdata[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counters and trigger status; software writes win over counting

    always_ff @(posedge clk) begin
        if (!resetn) begin
            cntLo_q <= 16'h0000;
            cntHi_q <= 16'h0000;
            armed_q <= 1'b0;
        end else if (ce) begin
            cntLo_q <= wrCntLo ? hwdata[15:0] : cntLo_d;
            cntHi_q <= wrCntHi ? hwdata[15:0] : cntHi_d;
            // Trigger beats a clear in the same cycle
            armed_q <= trigEvent | (armed_q & ~trClrWr);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Events and interrupt; a new event wins over a read clear

    wire [2:0] irqSet = {trigEvent, cmpEv, syncEv};

    always_ff @(posedge clk) begin
        if (!resetn) begin
            irqStat_q      <= 3'h0;
            syncOut_q      <= 1'b0;
            compareEvent_q <= 1'b0;
            irq_q          <= 1'b0;
        end else if (ce) begin
            irqStat_q      <= irqSet | (irqStat_q & {3{~rdIrqStat}});
            syncOut_q      <= syncEv;
            compareEvent_q <= cmpEv;
            irq_q          <= |((irqSet | (irqStat_q & {3{~rdIrqStat}}))
                                & irqMask_q);
        end
    end

    assign hrdata       = hrdata_q;
    assign hreadyout    = hready_q;
    assign hresp        = `CGT_HRESP_OKAY;
    assign syncOut      = syncOut_q;
    assign compareEvent = compareEvent_q;
    assign irq          = irq_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    mode_hold_a: assert property (
        @(posedge clk) disable iff (!resetn)
        ce && !timerMode && !wrCntLo && !wrCntHi
        |=> $stable(cntLo_q) && $stable(cntHi_q) && !syncOut_q)
        else $error("counters moved outside timer mode");

    sync_clear_a: assert property (
        @(posedge clk) disable iff (!resetn)
        ce && timerMode && !trigger_mode_enable && selIn && !wrCntLo
        |=> cntLo_q == 16'h0000)
        else $error("sync input did not clear timer");

    dual_wrap_a: assert property (
        @(posedge clk) disable iff (!resetn)
        ce && mode == cgt_pkg::CGT_DUAL && lowMatch && !primClr && !wrCntLo
        |=> cntLo_q == 16'h0000 && syncOut_q)
        else $error("primary wrap or sync out wrong");

    sec_compare_a: assert property (
        @(posedge clk) disable iff (!resetn)
        ce && mode == cgt_pkg::CGT_DUAL && hiMatch |=> compareEvent_q)
        else $error("secondary match gave no compare event");

    sec_nosync_a: assert property (
        @(posedge clk) disable iff (!resetn)
        ce && mode == cgt_pkg::CGT_DUAL && hiMatch && !lowMatch
        |=> !syncOut_q)
        else $error("secondary match drove sync out");

    wide_carry_a: assert property (
        @(posedge clk) disable iff (!resetn)
        ce && mode == cgt_pkg::CGT_WIDE && !primClr && !wideMatch
        && cntLo_q == 16'hffff && !wrCntLo && !wrCntHi
        |=> cntLo_q == 16'h0000 && cntHi_q == $past(cntHi_q) + 16'h0001)
        else $error("low overflow did not carry");

    trig_hold_a: assert property (
        @(posedge clk) disable iff (!resetn)
        ce && timerMode && trigger_mode_enable && !armed_q && !selIn && !wrCntLo
        |=> cntLo_q == 16'h0000 && !armed_q)
        else $error("timer ran before trigger");

    trig_arm_a: assert property (
        @(posedge clk) disable iff (!resetn)
        ce && trigEvent |=> armed_q)
        else $error("trigger did not set armed status");

    trig_clear_a: assert property (
        @(posedge clk) disable iff (!resetn)
        ce && timerMode && trClrWr && !trigEvent && !wrCntLo
        |=> !armed_q && cntLo_q == 16'h0000)
        else $error("trigger clear did not reset timer");

    trig_keep_a: assert property (
        @(posedge clk) disable iff (!resetn)
        ce && armed_q && !trClrWr
        |=> armed_q)
        else $error("armed status dropped without clear");

    sec_free_a: assert property (
        @(posedge clk) disable iff (!resetn)
        ce && mode == cgt_pkg::CGT_DUAL && primClr && !hiMatch && !wrCntHi
        |=> cntHi_q == $past(cntHi_q) + 16'h0001)
        else $error("secondary counter disturbed by sync");

    wide_wrap_a: assert property (
        @(posedge clk) disable iff (!resetn)
        ce && mode == cgt_pkg::CGT_WIDE && wideMatch && !wrCntLo && !wrCntHi
        |=> cntLo_q == 16'h0000 && cntHi_q == 16'h0000)
        else $error("wide timer did not wrap after match");

    cmp_sticky_a: assert property (
        @(posedge clk) disable iff (!resetn)
        ce && cmpEv
        |=> irqStat_q[`CGT_IRQ_CMP])
        else $error("compare event lost in status");

    irq_level_a: assert property (
        @(posedge clk) disable iff (!resetn)
        ce
        |=> irq_q == |(irqStat_q & $past(irqMask_q)))
        else $error("interrupt level does not match status");

endmodule : cgt_timer
`default_nettype wire

// File: testbench/cgt_peer_model.sv
// Peer timer model that raises sync sources and follows the sync output
`timescale 1ns/1ps
`default_nettype none

module cgt_peer_model (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        syncOut,
    input  wire logic        fire,
    input  wire logic [4:0]  fireIdx,
    output logic      [31:0] syncSources,
    output int               syncSeen
);
    // peer counts sync pulses and drives one source at a time
    always @(posedge clk) begin
        if (!resetn) begin
            syncSources <= 32'h0;
            syncSeen    <= 0;
        end else begin
            // One-cycle pulse; lines fall back to 0 so a stale level never clears
            syncSources <= fire ? (32'h1 << fireIdx) : 32'h0;
            syncSeen    <= syncSeen + ((syncOut === 1'b1) ? 1 : 0);
        end
    end
endmodule : cgt_peer_model

`default_nettype wire

// File: testbench/tb_top.sv
// Self-checking bench of the general purpose timer
`timescale 1ns/1ps
`default_nettype none
`include "cgt_consts.svh"

module tb_top;
    logic        clk, resetn, ce, hsel, hwrite, fire;
    logic [31:0] haddr, hwdata, hrdata, syncSources, r;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [4:0]  fireIdx;
    logic        hreadyout, hresp, syncOut, compareEvent, irq;
    wire  [1:0]  ev = {compareEvent, syncOut};
    int          n_fail, n_compared, g, n, p, idx, i, seenCnt, s0;

    cgt_timer i_dut (.clk(clk), .resetn(resetn), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .syncSources(syncSources),
        .syncOut(syncOut), .compareEvent(compareEvent), .irq(irq));

    cgt_peer_model i_peer (.clk(clk), .resetn(resetn), .syncOut(syncOut),
        .fire(fire), .fireIdx(fireIdx), .syncSources(syncSources),
        .syncSeen(seenCnt));

    always #20 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("Compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Value at the negedge is what the next rising edge samples
    task automatic waitRdy;
        do @(negedge clk); while (hreadyout !== 1'b1);
    endtask : waitRdy

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h0, a};
        hwrite <= w;
        waitRdy();
        @(posedge clk);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        waitRdy();
        rd = hrdata;
        @(posedge clk);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        bus(1'b1, a, d, unused);
    endtask : wr

    task automatic rdr(input logic [7:0] a);
        bus(1'b0, a, 32'h0, r);
    endtask : rdr

    // Cycles until the selected pulse, bounded by lim
    task automatic waitEv(input int sel, input int lim, output int c);
        c = 1;
        @(negedge clk);
        while (ev[sel] !== 1'b1 && c < lim) begin
            @(negedge clk);
            c++;
        end
        @(posedge clk);
    endtask : waitEv

    task automatic kick(input int k);
        fire    <= 1'b1;
        fireIdx <= k[4:0];
        @(posedge clk);
        fire    <= 1'b0;
        @(posedge clk);
    endtask : kick

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        conclude();
    end

    initial begin
        clk = 1'b0; resetn = 1'b0; ce = 1'b1; hsel = 1'b0; haddr = 32'h0;
        htrans = 2'b00; hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
        fire = 1'b0; fireIdx = 5'h0; n_fail = 0; n_compared = 0;
        void'($urandom(26));
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rdr(`CGT_OFF_PER_LO); check("period_low", r, 32'h0000ffff);
        rdr(`CGT_OFF_CTRL_LO); check("ctrl_lo", r, 32'h0);
        wr(8'h24, 32'h1234); rdr(8'h24); check("unmapped", r, 32'h0);
        check("bus_okay", hresp, 32'h0);
        // Timer must stay still unless enabled with capture 0, function 0
        for (i = 0; i < 3; i++) begin
            wr(`CGT_OFF_CTRL_LO, i == 0 ? 32'h8010 : i == 1 ? 32'h8001 : 0);
            wr(`CGT_OFF_CNT_LO, 32'h0);
            repeat (20) @(posedge clk);
            rdr(`CGT_OFF_CNT_LO); check("held_count", r, 32'h0);
        end
        // Dual mode, independent periods
        p = $urandom_range(20, 2);
        wr(`CGT_OFF_PER_LO, p);
        wr(`CGT_OFF_PER_HI, 32'h4);
        wr(`CGT_OFF_CTRL_HI, 32'h0);
        wr(`CGT_OFF_CTRL_LO, 32'h8000);
        waitEv(0, 400, n);
        s0 = seenCnt;
        waitEv(0, 400, g);
        check("sync_gap", g, p + 1);
        check("peer_sync", seenCnt - s0, 32'h1);
        waitEv(1, 400, n); waitEv(1, 400, g);
        check("cmp_gap", g, 32'd5);
        // Interrupt mask and read-to-clear
        wr(`CGT_OFF_CTRL_LO, 32'h0);
        wr(`CGT_OFF_IRQ_MASK, 32'h0);
        repeat (3) @(posedge clk);
        check("irq_masked", irq, 32'h0);
        wr(`CGT_OFF_IRQ_MASK, 32'h7);
        repeat (3) @(posedge clk);
        check("irq_on", irq, 32'h1);
        rdr(`CGT_OFF_IRQ_STAT); check("irq_stat", r, 32'h3);
        repeat (3) @(posedge clk);
        check("irq_off", irq, 32'h0);
        // width first, then periods and counters
        wr(`CGT_OFF_CTRL_LO, 32'h0020);
        wr(`CGT_OFF_PER_HI, 32'h1);
        wr(`CGT_OFF_PER_LO, 32'h2);
        wr(`CGT_OFF_CNT_HI, 32'h0);
        wr(`CGT_OFF_CNT_LO, 32'hfff0);
        wr(`CGT_OFF_CTRL_LO, 32'h8020);
        // 18 counts to the match, one edge to enable, one to register
        waitEv(1, 60, n);
        check("wide_carry", n, 32'h10002 - 32'hfff0 + 32'd2);
        // Sync operation; source 31 never picked
        wr(`CGT_OFF_CTRL_LO, 32'h8000);
        wr(`CGT_OFF_PER_LO, 32'hffff);
        wr(`CGT_OFF_PER_HI, 32'hffff);
        wr(`CGT_OFF_CNT_LO, 32'h0);
        for (i = 0; i < 3; i++) begin
            idx = $urandom_range(30, 0);
            wr(`CGT_OFF_CTRL_HI, idx);
            repeat (100) @(posedge clk);
            kick((idx + 1) % 31);
            rdr(`CGT_OFF_CNT_LO); check("sync_other", r >= 100, 32'h1);
            kick(idx);
            rdr(`CGT_OFF_CNT_LO); check("sync_clr", r < 16, 32'h1);
        end
        // Trigger operation; clock select left at 000
        wr(`CGT_OFF_CTRL_HI, 32'h80 | idx);
        wr(`CGT_OFF_STATUS, 32'h20);
        repeat (20) @(posedge clk);
        rdr(`CGT_OFF_CNT_LO); check("trig_hold", r, 32'h0);
        rdr(`CGT_OFF_STATUS); check("armed_0", r[7], 32'h0);
        kick(idx);
        repeat (20) @(posedge clk);
        rdr(`CGT_OFF_STATUS); check("armed_1", r[7], 32'h1);
        rdr(`CGT_OFF_CNT_LO); check("trig_run", r >= 16, 32'h1);
        // Clock enable low freezes the running count
        g = r;
        ce <= 1'b0;
        repeat (50) @(posedge clk);
        ce <= 1'b1;
        rdr(`CGT_OFF_CNT_LO); check("ce_freeze", r - g < 16, 32'h1);
        rdr(`CGT_OFF_IRQ_STAT); check("irq_trig", r[2], 32'h1);
        wr(`CGT_OFF_STATUS, 32'h20);
        rdr(`CGT_OFF_STATUS); check("armed_clr", r[7], 32'h0);
        repeat (20) @(posedge clk);
        rdr(`CGT_OFF_CNT_LO); check("trig_zero", r, 32'h0);
        conclude();
    end
endmodule : tb_top

`default_nettype wire
